// ---- core/tro_pkg.sv ----
// Constants and types for the telemetry receiver output control block.
// Assumes one 20 MHz clock and an on-chip demodulator that hands over decoded packets.
package tro_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_RATE = 19_200;
  localparam int unsigned BAUD_DIV = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int unsigned LEARN_TIMEOUT_MS = 10_000;
  localparam int unsigned ERASE_HOLD_MS = 10_000;
  localparam int unsigned FLASH_HALF_MS = 150;
  localparam int unsigned LEARN_CYC_DEF = LEARN_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned ERASE_CYC_DEF = ERASE_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_CYC_DEF = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W = 28;
  localparam int unsigned BAUD_W = 11;
  localparam int unsigned NUM_PAIRS = 30;
  localparam int unsigned NUM_OUT = 4;
  localparam logic [2:0] SEL_MAX = 3'h4;
  localparam logic [2:0] FLASH_PAIRED = 3'h2;
  localparam logic [2:0] FLASH_ERASED = 3'h3;
  localparam logic [1:0] SYNC_SETTLE = 2'h2;
  localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
  localparam logic [2:0] RECORD_TAIL_BYTES = 3'h6;
  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAST_ID = 4'h8;
  localparam int unsigned CTRL_TX_EN_BIT = 0;
  localparam int unsigned CTRL_ERASE_BIT = 1;
  localparam int unsigned STATUS_OVR_BIT = 15;
  localparam logic CTRL_TX_EN_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [23:0] id;
    logic [15:0] inputs;
    logic low_batt;
    logic [7:0] rssi;
  } tro_pkt_t;

  typedef struct packed {
    logic valid;
    logic [23:0] id;
    logic [3:0] inp;
    logic [1:0] out;
    logic last;
  } tro_pair_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic overrun;
    logic [4:0] pair_cnt;
    logic [2:0] sel;
    logic learning;
    logic latch_mode;
    logic asleep;
    logic [3:0] outs;
  } tro_status_t;

  typedef enum logic [1:0] {
    LS_NORMAL = 2'h0,
    LS_SELECT = 2'h1,
    LS_HELD = 2'h3
  } tro_learn_t;
endpackage

// ---- core/tro_output_ctrl.sv ----
// Output control behind a four-output telemetry receiver: pairing, outputs, LED and serial record.
// Assumes decoded packets arrive on aclk from the demodulator; pins are asynchronous.
`timescale 1ns/1ns
module tro_output_ctrl
  import tro_pkg::*;
#(
  parameter int unsigned LEARN_CYC = LEARN_CYC_DEF,
  parameter int unsigned ERASE_CYC = ERASE_CYC_DEF,
  parameter int unsigned FLASH_CYC = FLASH_CYC_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Demodulator side
  input wire logic rx_pkt_valid,
  input wire tro_pkt_t rx_pkt,
  input wire logic rx_active,
  // Pins
  input wire logic sleep_pin,
  input wire logic hold_style_select,
  input wire logic learn_pin_indicator_i,
  output logic learn_pin_indicator_o,
  output logic learn_pin_indicator_oe,
  output logic telemetry_out_1,
  output logic telemetry_out_2,
  output logic telemetry_out_3,
  output logic telemetry_out_4,
  output logic serial_tx
);

  logic [1:0] sleep_s_q, hold_s_q, learn_s_q;
  logic asleep, pin_low;
  logic [1:0] settle_q;
  logic mode_taken_q, latch_mode_q;
  logic press_q, led_q, oe_q, pin_o_q;
  logic [1:0] blank_q;
  logic blank, press_edge, release_edge;
  tro_learn_t state_q;
  logic [2:0] sel_q, sel_next;
  logic [TMR_W-1:0] learn_tmr_q, hold_tmr_q, flash_tmr_q;
  logic erased_q, erase_now, sw_erase_q;
  logic [2:0] flash_left_q, flash_num;
  logic flash_on_q, flash_go;
  logic pkt_acc, store_now;
  tro_pair_t pairs_q [NUM_PAIRS];
  logic [NUM_PAIRS-1:0] hit, cur, chg;
  logic free_ok, paired;
  logic [4:0] free_idx, pair_cnt;
  logic [3:0] low_inp;
  logic [NUM_OUT-1:0] out_d, out_q;
  logic tx_busy_q, overrun_q, tx_en_q;
  logic [9:0] shift_q;
  logic [47:0] rec_q;
  logic [2:0] bytes_left_q;
  logic [3:0] bit_q;
  logic [BAUD_W-1:0] baud_q;
  logic [23:0] last_id_q;
  logic [3:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, wr_hit_ctrl, wr_hit_stat;
  tro_status_t status;

  // Two-stage synchronisers for every pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_s_q <= 2'h0;
      hold_s_q <= 2'h3;
      learn_s_q <= 2'h3;
    end else begin
      sleep_s_q <= {sleep_s_q[0], sleep_pin};
      hold_s_q <= {hold_s_q[0], hold_style_select};
      learn_s_q <= {learn_s_q[0], learn_pin_indicator_i};
    end
  end

  assign asleep = sleep_s_q[1];
  assign pin_low = !learn_s_q[1];

  // Mode caught once after reset release, once the synchroniser has filled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_q <= 2'h0;
      mode_taken_q <= 1'b0;
      latch_mode_q <= 1'b1;
    end else if (!mode_taken_q) begin
      if (settle_q == SYNC_SETTLE) begin
        mode_taken_q <= 1'b1;
        latch_mode_q <= hold_s_q[1];
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // Our own LED drive reads back low, so presses are blanked while and just after we drive
  assign blank = oe_q | (|blank_q);
  assign press_edge = pin_low && !press_q && !blank;
  assign release_edge = !pin_low && press_q && !blank;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      press_q <= 1'b0;
      blank_q <= 2'h0;
    end else begin
      blank_q <= {blank_q[0], oe_q};
      if (!blank) begin
        press_q <= pin_low;
      end
    end
  end

  assign pkt_acc = rx_pkt_valid && !asleep;
  assign store_now = (state_q == LS_SELECT) && pkt_acc && (|rx_pkt.inputs) && !press_edge;
  assign sel_next = (sel_q >= SEL_MAX || sel_q == 3'h0) ? 3'h1 : sel_q + 3'h1;
  assign erase_now = ((state_q == LS_HELD) && !erased_q && hold_tmr_q == TMR_W'(ERASE_CYC - 1)) || sw_erase_q;
  assign flash_go = ((state_q == LS_HELD) && release_edge) || store_now;
  assign flash_num = store_now ? FLASH_PAIRED : (erased_q ? FLASH_ERASED : sel_next);

  // Learn, select and erase sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= LS_NORMAL;
      sel_q <= 3'h0;
      learn_tmr_q <= '0;
      hold_tmr_q <= '0;
      erased_q <= 1'b0;
    end else if (asleep) begin
      state_q <= LS_NORMAL;
      sel_q <= 3'h0;
      erased_q <= 1'b0;
    end else begin
      case (state_q)
        LS_NORMAL: begin
          if (press_edge) begin
            state_q <= LS_HELD;
            hold_tmr_q <= '0;
            erased_q <= 1'b0;
          end
        end
        LS_SELECT: begin
          learn_tmr_q <= learn_tmr_q + TMR_W'(1);
          if (press_edge) begin
            state_q <= LS_HELD;
            hold_tmr_q <= '0;
            erased_q <= 1'b0;
          end else if (store_now) begin
            state_q <= LS_NORMAL;
            sel_q <= 3'h0;
          end else if (learn_tmr_q == TMR_W'(LEARN_CYC - 1)) begin
            state_q <= LS_NORMAL;
            sel_q <= 3'h0;
          end
        end
        LS_HELD: begin
          if (hold_tmr_q != TMR_W'(ERASE_CYC - 1)) begin
            hold_tmr_q <= hold_tmr_q + TMR_W'(1);
          end
          if (erase_now) begin
            erased_q <= 1'b1;
          end
          if (release_edge) begin
            learn_tmr_q <= '0;
            if (erased_q) begin
              state_q <= LS_NORMAL;
              sel_q <= 3'h0;
            end else begin
              state_q <= LS_SELECT;
              sel_q <= sel_next;
            end
          end
        end
        default: begin
          state_q <= LS_NORMAL;
          sel_q <= 3'h0;
        end
      endcase
    end
  end

  // Flash engine: a count of on/off pairs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_left_q <= 3'h0;
      flash_on_q <= 1'b0;
      flash_tmr_q <= '0;
    end else if (flash_go) begin
      flash_left_q <= flash_num;
      flash_on_q <= 1'b1;
      flash_tmr_q <= '0;
    end else if (flash_left_q != 3'h0) begin
      if (flash_tmr_q == TMR_W'(FLASH_CYC - 1)) begin
        flash_tmr_q <= '0;
        flash_on_q <= !flash_on_q;
        if (flash_on_q) begin
          flash_left_q <= flash_left_q - 3'h1;
        end
      end else begin
        flash_tmr_q <= flash_tmr_q + TMR_W'(1);
      end
    end
  end

  // Held-low lighting comes from the external ground itself; we sink the pin to flash, and while awake and rx_active in normal state with no flash left
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q <= 1'b0;
      pin_o_q <= 1'b0;
    end else begin
      oe_q <= flash_on_q || (state_q == LS_NORMAL && rx_active && !asleep && flash_left_q == 3'h0);
      pin_o_q <= 1'b0;
    end
  end

  always_comb begin
    free_ok = 1'b0;
    free_idx = 5'h0;
    pair_cnt = 5'h0;
    low_inp = 4'h0;
    for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
      if (!pairs_q[i].valid) begin
        free_ok = 1'b1;
        free_idx = 5'(i);
      end
      pair_cnt = pair_cnt + {4'h0, pairs_q[i].valid};
    end
    for (int i = 15; i >= 0; i--) begin
      if (rx_pkt.inputs[i]) begin
        low_inp = 4'(i);
      end
    end
  end

  // Pairing memory, one entry per generate slot
  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
    assign hit[g] = pairs_q[g].valid && pairs_q[g].id == rx_pkt.id;
    assign cur[g] = rx_pkt.inputs[pairs_q[g].inp];
    assign chg[g] = hit[g] && (cur[g] != pairs_q[g].last);
    always_ff @(posedge aclk) begin
      if (!aresetn || erase_now) begin
        pairs_q[g] <= '0;
      end else if (store_now && free_ok && free_idx == 5'(g)) begin
        pairs_q[g] <= '{valid: 1'b1, id: rx_pkt.id, inp: low_inp, out: 2'(sel_q - 3'h1), last: 1'b1};
      end else if (pkt_acc && state_q == LS_NORMAL && chg[g]) begin
        pairs_q[g].last <= cur[g];
      end
    end
  end

  assign paired = |hit;

  always_comb begin
    out_d = out_q;
    if (asleep) begin
      out_d = '0;
    end else if (pkt_acc && state_q == LS_NORMAL) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        if (chg[i]) begin
          if (!latch_mode_q) begin
            out_d[pairs_q[i].out] = cur[i];
          end else if (!cur[i]) begin
            out_d[pairs_q[i].out] = !out_d[pairs_q[i].out];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign telemetry_out_1 = out_q[0];
  assign telemetry_out_2 = out_q[1];
  assign telemetry_out_3 = out_q[2];
  assign telemetry_out_4 = out_q[3];
  assign learn_pin_indicator_o = pin_o_q;
  assign learn_pin_indicator_oe = oe_q;

  // Serial record; idle shift register holds ones so the line rests high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_q <= 1'b0;
      shift_q <= 10'h3ff;
      rec_q <= '0;
      bytes_left_q <= 3'h0;
      bit_q <= 4'h0;
      baud_q <= '0;
    end else if (!tx_busy_q) begin
      if (pkt_acc && tx_en_q) begin
        tx_busy_q <= 1'b1;
        shift_q <= {1'b1, rx_pkt.id[23:16], 1'b0};
        rec_q <= {rx_pkt.id[15:0], rx_pkt.inputs[7:0], rx_pkt.inputs[15:8],
                  6'h0, paired, rx_pkt.low_batt, rx_pkt.rssi};
        bytes_left_q <= RECORD_TAIL_BYTES;
        bit_q <= 4'h0;
        baud_q <= '0;
      end
    end else if (baud_q == BAUD_W'(BAUD_DIV - 1)) begin
      baud_q <= '0;
      if (bit_q == FRAME_LAST_BIT) begin
        bit_q <= 4'h0;
        if (bytes_left_q == 3'h0) begin
          tx_busy_q <= 1'b0;
          shift_q <= 10'h3ff;
        end else begin
          shift_q <= {1'b1, rec_q[47:40], 1'b0};
          rec_q <= {rec_q[39:0], 8'h00};
          bytes_left_q <= bytes_left_q - 3'h1;
        end
      end else begin
        bit_q <= bit_q + 4'h1;
        shift_q <= {1'b1, shift_q[9:1]};
      end
    end else begin
      baud_q <= baud_q + BAUD_W'(1);
    end
  end

  assign serial_tx = shift_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_id_q <= 24'h0;
    end else if (pkt_acc) begin
      last_id_q <= rx_pkt.id;
    end
  end

  // AXI4-Lite slave: address and data taken in either order, one write and one read at a time
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit_ctrl = wr_go && aw_addr_q == REG_CTRL;
  assign wr_hit_stat = wr_go && aw_addr_q == REG_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == REG_CTRL || aw_addr_q == REG_STATUS || aw_addr_q == REG_LAST_ID)
                       ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control bits; erase is a self-clearing request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en_q <= CTRL_TX_EN_RST;
      sw_erase_q <= 1'b0;
    end else begin
      sw_erase_q <= wr_hit_ctrl && wstrb_q[0] && wdata_q[CTRL_ERASE_BIT];
      if (wr_hit_ctrl && wstrb_q[0]) begin
        tx_en_q <= wdata_q[CTRL_TX_EN_BIT];
      end
    end
  end

  // Overrun: a packet lost while a record is still going out; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_q <= 1'b0;
    end else if (pkt_acc && tx_busy_q) begin
      overrun_q <= 1'b1;
    end else if (wr_hit_stat && wstrb_q[1] && wdata_q[STATUS_OVR_BIT]) begin
      overrun_q <= 1'b0;
    end
  end

  assign status = '{rsvd: 16'h0, overrun: overrun_q, pair_cnt: pair_cnt, sel: sel_q,
                    learning: state_q != LS_NORMAL, latch_mode: latch_mode_q, asleep: asleep, outs: out_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {30'h0, 1'b0, tx_en_q};
        REG_STATUS: s_axi_rdata <= status;
        REG_LAST_ID: s_axi_rdata <= {8'h00, last_id_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  AST_SLEEP_OFF: assert property (@(posedge aclk) disable iff (!aresetn) asleep |=> out_q == '0)
    else $error("outputs not cleared in sleep");
  AST_NO_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    !pkt_acc && !asleep |=> $stable(out_q))
    else $error("outputs moved without a packet");
  AST_MODE_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_taken_q && $past(mode_taken_q) |-> $stable(latch_mode_q))
    else $error("mode changed after capture");
  AST_REPEAT: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_acc && !asleep && chg == '0 |=> out_q == $past(out_q))
    else $error("unchanged input moved an output");
  AST_MOM_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    !latch_mode_q && pkt_acc && state_q == LS_NORMAL && chg == NUM_PAIRS'(1)
    |=> out_q[pairs_q[0].out] == $past(cur[0]))
    else $error("momentary output does not follow input");
  AST_RECORD: assert property (@(posedge aclk) disable iff (!aresetn)
    pkt_acc && !tx_busy_q && tx_en_q |=> tx_busy_q && !serial_tx)
    else $error("record not started with start bit");
  AST_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == LS_SELECT && learn_tmr_q == TMR_W'(LEARN_CYC - 1) && !press_edge && !store_now && !asleep
    |=> state_q == LS_NORMAL && sel_q == 3'h0)
    else $error("learn mode did not time out");
  AST_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    store_now && free_ok && !erase_now |=> pair_cnt == $past(pair_cnt) + 5'h1 && flash_left_q == FLASH_PAIRED)
    else $error("pairing not stored");
  AST_FULL: assert property (@(posedge aclk) disable iff (!aresetn)
    store_now && !free_ok && !erase_now |=> pair_cnt == 5'(NUM_PAIRS))
    else $error("pairing memory overflow");
  AST_ERASE: assert property (@(posedge aclk) disable iff (!aresetn) erase_now |=> pair_cnt == 5'h0)
    else $error("erase left pairings");
  AST_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == LS_SELECT |-> sel_q >= 3'h1 && sel_q <= SEL_MAX)
    else $error("selected output out of range");
  AST_BHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule

// ---- verification/tro_uart_host.sv ----
// Host receiver model: decodes 8N1 frames from the serial record line into a byte queue.
// Assumes the line idles high and runs at BAUD_DIV clock cycles per bit.
`timescale 1ns/1ns
module tro_uart_host
  import tro_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Serial line from the device
  input wire logic serial_tx
);
  logic [7:0] rx_q[$];
  int frame_err = 0;

  // Sample mid-bit so edge placement jitter cannot flip a bit
  initial begin
    logic [7:0] b;
    forever begin
      @(posedge aclk);
      if (serial_tx === 1'b0) begin
        repeat (BAUD_DIV / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD_DIV) @(posedge aclk);
          b[i] = serial_tx;
        end
        repeat (BAUD_DIV) @(posedge aclk);
        if (serial_tx !== 1'b1) frame_err++;
        rx_q.push_back(b);
      end
    end
  end
endmodule

// ---- verification/telemetry_rx_output_control_tb.sv ----
// Bench for the output control block: AXI4-Lite master, packet source, learn pin and host model.
// Assumes shortened learn, erase and flash counts set by parameters.
`timescale 1ns/1ns
module telemetry_rx_output_control_tb import tro_pkg::*; ;
  logic aclk = 0;
  logic aresetn = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, lo, loe, serial_tx;
  logic [1:0] bresp, rresp;
  logic pv = 0, ract = 0, slp = 0, hss = 0, lp_drv = 1, oe_q = 0, lb = 0;
  logic [7:0] rs = 0;
  logic [3:0] outs;
  logic [23:0] pid;
  tro_pkt_t pkt = '0;
  int err_total = 0, checks_done = 0, flashes = 0, exp1 = 0, last1 = 1, n;
  bit slp_m = 0, paired_m = 0, lat_m = 0;
  logic [7:0] eb[7];
  // Open-drain pin: the device only ever pulls low
  wire logic lp = loe ? lo : lp_drv;

  tro_output_ctrl #(.LEARN_CYC(200), .ERASE_CYC(100), .FLASH_CYC(4)) u_tro_output_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pkt_valid(pv),
    .rx_pkt(pkt), .rx_active(ract), .sleep_pin(slp), .hold_style_select(hss),
    .learn_pin_indicator_i(lp), .learn_pin_indicator_o(lo), .learn_pin_indicator_oe(loe),
    .telemetry_out_1(outs[0]), .telemetry_out_2(outs[1]), .telemetry_out_3(outs[2]),
    .telemetry_out_4(outs[3]), .serial_tx(serial_tx));
  tro_uart_host u_host (.aclk(aclk), .serial_tx(serial_tx));

  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    oe_q <= loe;
    if (loe && !oe_q) flashes++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dd, input logic [3:0] s, input logic [1:0] er);
    int k = 0;
    bit aw = 0, w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dd;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w) && k < 50) begin
      @(posedge aclk);
      k++;
      if (awvalid && awready === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (wvalid && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 100) err_total++;
    chk(32'(bresp), 32'(er), "bresp");
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] q);
    int k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (rvalid !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
      if (arvalid && arready === 1'b1) arvalid <= 0;
    end
    if (k >= 100) err_total++;
    q = rdata;
    chk(32'(rresp), 32'(er), "rresp");
    rready <= 0;
  endtask

  task automatic send(input logic [23:0] id, input logic [15:0] in, input bit fl);
    @(posedge aclk);
    ract <= 1;
    repeat (3) @(posedge aclk);
    if (fl) chk(32'(loe), 32'h1, "flicker");
    pv <= 1;
    pkt <= '{id: id, inputs: in, low_batt: lb, rssi: rs};
    @(posedge aclk);
    pv <= 0;
    ract <= 0;
    if (!slp_m && paired_m && id == pid && int'(in[0]) != last1) begin
      if (!lat_m) exp1 = in[0];
      else if (!in[0]) exp1 = 1 - exp1;
      last1 = in[0];
    end
    repeat (2) @(posedge aclk);
    chk(32'(outs[0]), 32'(exp1), "out1");
  endtask

  task rst;
    aresetn <= 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (5) @(posedge aclk);
  endtask

  task press(input int c);
    @(posedge aclk);
    lp_drv <= 0;
    repeat (c) @(posedge aclk);
    lp_drv <= 1;
  endtask

  initial begin
    void'($urandom(69));
    pid = 24'($urandom);
    lb = 1'($urandom);
    rs = 8'($urandom);
    rst();
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[5]), 32'h0, "mode");
    axi_rd(REG_CTRL, RESP_OKAY, d);
    chk(d, 32'h1, "ctrl");
    axi_rd(4'hc, RESP_SLVERR, d);
    axi_wr(4'hc, 32'h0, 4'hf, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h0, 4'hf, RESP_OKAY);
    $display("test reset done");
    for (int k = 1; k <= 5; k++) begin
      flashes = 0;
      press(10);
      repeat (50) @(posedge aclk);
      axi_rd(REG_STATUS, RESP_OKAY, d);
      chk(32'(d[9:7]), 32'((k - 1) % 4 + 1), "select");
      chk(32'(flashes), 32'((k - 1) % 4 + 1), "flashes");
    end
    flashes = 0;
    send(pid, 16'h0001, 0);
    paired_m = 1;
    repeat (40) @(posedge aclk);
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[14:10]), 32'h1, "pairs");
    chk(32'(d[6]), 32'h0, "learning");
    chk(32'(flashes), 32'h2, "pair flashes");
    $display("test learn done");
    axi_wr(REG_CTRL, 32'h1, 4'h1, RESP_OKAY);
    eb = '{pid[23:16], pid[15:8], pid[7:0], 8'h00, 8'h81, {6'h0, 1'b1, lb}, rs};
    send(pid, 16'h8100, 1);
    send(pid, 16'h0001, 0);
    send(pid, 16'h0001, 0);
    send(pid ^ 24'h1, 16'h0001, 0);
    axi_rd(REG_LAST_ID, RESP_OKAY, d);
    chk(32'(d[23:0]), 32'(pid ^ 24'h1), "last id");
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[15]), 32'h1, "overrun");
    send(pid, 16'h0000, 0);
    send(pid, 16'h0001, 0);
    slp <= 1;
    slp_m = 1;
    exp1 = 0;
    repeat (6) @(posedge aclk);
    chk(32'(outs), 32'h0, "sleep outs");
    send(pid, 16'h0000, 0);
    slp <= 0;
    slp_m = 0;
    $display("test outputs done");
    n = 0;
    while (u_host.rx_q.size() < 7 && n < 80000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 80000) err_total++;
    for (int i = 0; i < 7; i++) chk(32'(u_host.rx_q[i]), 32'(eb[i]), "record");
    chk(32'(u_host.frame_err), 32'h0, "framing");
    axi_wr(REG_STATUS, 32'h8000, 4'h2, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0, 4'h1, RESP_OKAY);
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[15]), 32'h0, "overrun clear");
    $display("test record done");
    press(10);
    repeat (260) @(posedge aclk);
    send(pid ^ 24'h2, 16'h0001, 0);
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[6]), 32'h0, "timeout");
    chk(32'(d[14:10]), 32'h1, "timeout pairs");
    flashes = 0;
    press(110);
    repeat (60) @(posedge aclk);
    chk(32'(flashes), 32'h3, "erase flashes");
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[14:10]), 32'h0, "erased");
    paired_m = 0;
    send(pid, 16'h0000, 0);
    $display("test learn timeout and erase done");
    hss <= 1;
    rst();
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[5]), 32'h1, "latch mode");
    hss <= 0;
    repeat (10) @(posedge aclk);
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[5]), 32'h1, "mode held");
    $display("test mode done");
    lat_m = 1;
    exp1 = 0;
    last1 = 1;
    press(10);
    repeat (30) @(posedge aclk);
    send(pid, 16'h0001, 0);
    paired_m = 1;
    send(pid, 16'h0000, 0);
    send(pid, 16'h0001, 0);
    chk(32'(outs[0]), 32'h1, "latched");
    axi_wr(REG_CTRL, 32'h2, 4'h1, RESP_OKAY);
    paired_m = 0;
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[14:10]), 32'h0, "sw erase");
    // Flash of the previous store must end before the next press is seen
    for (int k = 0; k <= 30; k++) begin
      repeat (20) @(posedge aclk);
      press(10);
      repeat (30) @(posedge aclk);
      send(24'(k), 16'h0001, 0);
    end
    axi_rd(REG_STATUS, RESP_OKAY, d);
    chk(32'(d[14:10]), 32'(NUM_PAIRS), "full");
    $display("test latch and full done");
    results();
  end

  // Record of 70 bits dominates the run
  initial begin
    repeat (95000) @(posedge aclk);
    err_total++;
    results();
  end
endmodule
